// ### rtl/artc_pkg.sv
package artc_pkg;

  // Byte addresses on the register bus.
  localparam logic [7:0] ADDR_CTRL   = 8'hC8;
  localparam logic [7:0] ADDR_CNT_LO = 8'hCC;
  localparam logic [7:0] ADDR_CNT_HI = 8'hD0;
  localparam logic [7:0] ADDR_RL_LO  = 8'hD4;
  localparam logic [7:0] ADDR_RL_HI  = 8'hD8;
  localparam logic [7:0] ADDR_CKSEL  = 8'hDC;
  localparam logic [7:0] ADDR_IRQEN  = 8'hE0;

  // Control register field positions.
  localparam int CTRL_HFLAG  = 7;
  localparam int CTRL_LFLAG  = 6;
  localparam int CTRL_LIEN   = 5;
  localparam int CTRL_CEN    = 4;
  localparam int CTRL_SPLIT  = 3;
  localparam int CTRL_RUN    = 2;
  localparam int CTRL_UNUSED = 1;
  localparam int CTRL_XCLK   = 0;

  // Clock select and interrupt enable field positions.
  localparam int CKSEL_HI_BIT = 5;
  localparam int CKSEL_LO_BIT = 4;
  localparam int IRQEN_BIT    = 5;

  // Reset values and masks.
  localparam logic [7:0]  CTRL_RESET = 8'h00;
  localparam logic [7:0]  CTRL_WMASK = 8'hFD;
  localparam logic [7:0]  BYTE_RESET = 8'h00;
  localparam logic [7:0]  BYTE_MAX   = 8'hFF;
  localparam logic [15:0] WORD_MAX   = 16'hFFFF;
  localparam logic [23:0] PAD_ZERO   = 24'h000000;

  // Prescaler ratios.
  localparam int         DIV12      = 12;
  localparam int         DIV8       = 8;
  localparam logic [3:0] DIV12_LAST = 4'(DIV12 - 1);
  localparam logic [2:0] DIV8_LAST  = 3'(DIV8 - 1);
  localparam logic [3:0] DIV12_ONE  = 4'h1;
  localparam logic [2:0] DIV8_ONE   = 3'h1;

endpackage

// ### rtl/artc_sync_edge.sv
module artc_sync_edge
  import artc_pkg::*;
(
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  input  wire logic d_i,
  output logic      rise_o,
  output logic      fall_o
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic rise;
    logic fall;
  } artc_sync_st_t;

  artc_sync_st_t q;
  artc_sync_st_t d;

  // Only the second stage reads the first one.
  always_comb begin
    d      = q;
    d.s1   = d_i;
    d.s2   = q.s1;
    d.s3   = q.s2;
    d.rise = q.s2 & ~q.s3;
    d.fall = ~q.s2 & q.s3;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rise_o = q.rise;
  assign fall_o = q.fall;

endmodule

// ### rtl/artc_prescale.sv
module artc_prescale
  import artc_pkg::*;
(
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  input  wire logic ext_rise_i,
  output logic      div12_tick_o,
  output logic      ext8_tick_o
);

  typedef struct packed {
    logic [3:0] c12;
    logic [2:0] c8;
    logic       t12;
    logic       t8;
  } artc_pre_st_t;

  artc_pre_st_t q;
  artc_pre_st_t d;

  always_comb begin
    d     = q;
    d.t12 = (q.c12 == DIV12_LAST);
    d.c12 = d.t12 ? 4'h0 : q.c12 + DIV12_ONE;
    d.t8  = ext_rise_i && (q.c8 == DIV8_LAST);
    if (ext_rise_i) begin
      d.c8 = q.c8 + DIV8_ONE;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign div12_tick_o = q.t12;
  assign ext8_tick_o  = q.t8;

endmodule

// ### rtl/artc_timer.sv
//
// Behaviour
// - Count is two bytes; split select at control bit 3 picks 16-bit or dual 8-bit.
// - Count clock is system clock, clock/12, or synchronised external oscillator/8.
// - 16-bit wrap from FFFF loads the reload bytes and sets the high flag.
// - 16-bit mode interrupts on every overflow while timer interrupt enable is set.
// - With low-byte interrupt enable too, low byte wrap also interrupts.
// - Split mode runs two 8-bit auto-reload timers from their own reload bytes.
// - Split mode run bit gates the high byte only; low byte always counts.
// - Per byte, clock select 1 gives system clock, else /12 or external /8.
// - High byte wrap sets high flag; low byte wrap sets low flag.
// - Split mode interrupts on high overflow, or either byte with low enable.
// - Hardware never clears the flags; software clears them and reads both.
// - Capture enabled: oscillator falling edge copies count to reload, sets high flag.
// - Capture mode count clock follows low-byte clock select and external select.
// - Control register at C8 resets to zero with the documented bit order.
// - Low flag is set on every low byte wrap in any mode.
// - Control bit 1 reads zero and ignores writes.
// - 16-bit mode counts only while run is set, else holds.
//
// Our own choice: the Avalon-MM interface to the registers.
module artc_timer
  import artc_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        ext_osc_i,
  input  wire logic        lfo_i,
  output logic             irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    logic [7:0]  cnt_lo;
    logic [7:0]  cnt_hi;
    logic [7:0]  rl_lo;
    logic [7:0]  rl_hi;
    logic [7:0]  ctrl;
    logic        ck_hi;
    logic        ck_lo;
    logic        t_ie;
    logic        wait_r;
    logic [31:0] rdata;
    logic        irq;
  } artc_core_st_t;

  artc_core_st_t q;
  artc_core_st_t d;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Clock sources.

  logic ext_rise;
  logic lfo_fall;
  logic div12_tick;
  logic ext8_tick;

  artc_sync_edge u_ext_sync (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .d_i       (ext_osc_i),
    .rise_o    (ext_rise),
    .fall_o    ()
  );

  artc_sync_edge u_lfo_sync (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .d_i       (lfo_i),
    .rise_o    (),
    .fall_o    (lfo_fall)
  );

  artc_prescale u_prescale (
    .ref_clk_i    (ref_clk_i),
    .rst_n_i      (rst_n_i),
    .ext_rise_i   (ext_rise),
    .div12_tick_o (div12_tick),
    .ext8_tick_o  (ext8_tick)
  );

  logic slow_tick;
  logic tick_lo;
  logic tick_hi;

  // The external oscillator is resynchronised before it is divided by eight.
  assign slow_tick = q.ctrl[CTRL_XCLK] ? ext8_tick : div12_tick;
  assign tick_lo   = q.ck_lo | slow_tick;
  assign tick_hi   = q.ck_hi | slow_tick;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode.

  logic       req;
  logic       acc_wr;
  logic [7:0] wb;
  logic       wr_ctrl;
  logic       wr_cnt_lo;
  logic       wr_cnt_hi;
  logic       wr_rl_lo;
  logic       wr_rl_hi;
  logic [7:0] rd_mux;

  assign req       = avs_read_i | avs_write_i;
  assign acc_wr    = avs_write_i & ~q.wait_r & avs_byteenable_i[0];
  assign wb        = avs_writedata_i[7:0];
  assign wr_ctrl   = acc_wr & hit(avs_address_i, ADDR_CTRL);
  assign wr_cnt_lo = acc_wr & hit(avs_address_i, ADDR_CNT_LO);
  assign wr_cnt_hi = acc_wr & hit(avs_address_i, ADDR_CNT_HI);
  assign wr_rl_lo  = acc_wr & hit(avs_address_i, ADDR_RL_LO);
  assign wr_rl_hi  = acc_wr & hit(avs_address_i, ADDR_RL_HI);

  always_comb begin
    rd_mux = BYTE_RESET;
    if (hit(avs_address_i, ADDR_CTRL)) begin
      rd_mux = q.ctrl;
    end else if (hit(avs_address_i, ADDR_CNT_LO)) begin
      rd_mux = q.cnt_lo;
    end else if (hit(avs_address_i, ADDR_CNT_HI)) begin
      rd_mux = q.cnt_hi;
    end else if (hit(avs_address_i, ADDR_RL_LO)) begin
      rd_mux = q.rl_lo;
    end else if (hit(avs_address_i, ADDR_RL_HI)) begin
      rd_mux = q.rl_hi;
    end else if (hit(avs_address_i, ADDR_CKSEL)) begin
      rd_mux[CKSEL_HI_BIT] = q.ck_hi;
      rd_mux[CKSEL_LO_BIT] = q.ck_lo;
    end else if (hit(avs_address_i, ADDR_IRQEN)) begin
      rd_mux[IRQEN_BIT] = q.t_ie;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state.

  logic        set_h;
  logic        set_l;
  logic        split;
  logic        run;
  logic [15:0] cnt16;

  assign split = q.ctrl[CTRL_SPLIT];
  assign run   = q.ctrl[CTRL_RUN];
  assign cnt16 = {q.cnt_hi, q.cnt_lo};

  always_comb begin
    d     = q;
    set_h = 1'b0;
    set_l = 1'b0;

    // Every request waits one cycle, then is answered for exactly one cycle.
    d.wait_r = ~(req & q.wait_r);
    if (req && q.wait_r) begin
      d.rdata = {PAD_ZERO, rd_mux};
    end

    if (!split) begin
      if (run && tick_lo) begin
        if (cnt16 == WORD_MAX) begin
          {d.cnt_hi, d.cnt_lo} = {q.rl_hi, q.rl_lo};
          set_h = 1'b1;
          set_l = 1'b1;
        end else begin
          {d.cnt_hi, d.cnt_lo} = cnt16 + 16'h0001;
          set_l = (q.cnt_lo == BYTE_MAX);
        end
      end
    end else begin
      // The low byte ignores the run bit in split mode.
      if (tick_lo) begin
        if (q.cnt_lo == BYTE_MAX) begin
          d.cnt_lo = q.rl_lo;
          set_l    = 1'b1;
        end else begin
          d.cnt_lo = q.cnt_lo + 8'h01;
        end
      end
      if (run && tick_hi) begin
        if (q.cnt_hi == BYTE_MAX) begin
          d.cnt_hi = q.rl_hi;
          set_h    = 1'b1;
        end else begin
          d.cnt_hi = q.cnt_hi + 8'h01;
        end
      end
    end

    // A bus write to a count byte overrides the increment in that cycle.
    if (wr_cnt_lo) begin
      d.cnt_lo = wb;
    end
    if (wr_cnt_hi) begin
      d.cnt_hi = wb;
    end
    if (wr_rl_lo) begin
      d.rl_lo = wb;
    end
    if (wr_rl_hi) begin
      d.rl_hi = wb;
    end

    // Capture takes precedence over a software write to the reload bytes.
    if (q.ctrl[CTRL_CEN] && lfo_fall) begin
      {d.rl_hi, d.rl_lo} = cnt16;
      set_h = 1'b1;
    end

    if (wr_ctrl) begin
      d.ctrl = wb & CTRL_WMASK;
    end
    // A hardware set wins over a clear written in the same cycle.
    d.ctrl[CTRL_HFLAG] = d.ctrl[CTRL_HFLAG] | set_h;
    d.ctrl[CTRL_LFLAG] = d.ctrl[CTRL_LFLAG] | set_l;

    if (acc_wr && hit(avs_address_i, ADDR_CKSEL)) begin
      d.ck_hi = wb[CKSEL_HI_BIT];
      d.ck_lo = wb[CKSEL_LO_BIT];
    end
    if (acc_wr && hit(avs_address_i, ADDR_IRQEN)) begin
      d.t_ie = wb[IRQEN_BIT];
    end

    // The same request term serves 16-bit, split and capture operation.
    d.irq = d.t_ie & (d.ctrl[CTRL_HFLAG] | (d.ctrl[CTRL_LIEN] & d.ctrl[CTRL_LFLAG]));
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q        <= '0;
      q.ctrl   <= CTRL_RESET;
      q.wait_r <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign avs_readdata_o    = q.rdata;
  assign avs_waitrequest_o = q.wait_r;
  assign irq_o             = q.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  logic wr_cnt_any;
  logic wr_rl_any;

  assign wr_cnt_any = wr_cnt_lo | wr_cnt_hi;
  assign wr_rl_any  = wr_rl_lo | wr_rl_hi;

  default clocking cb @(posedge ref_clk_i);
  endclocking

  default disable iff (!rst_n_i);

  sequence s_bus_req;
    req && avs_waitrequest_o;
  endsequence

  sequence s_bus_ack;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence

  property p_bus_answer;
    s_bus_req |=> s_bus_ack;
  endproperty

  chk_bus_answer: assert property (p_bus_answer)
    else $error("bus request not answered in one cycle");

  chk_wrap_reload: assert property (
    !split && run && tick_lo && cnt16 == WORD_MAX && !wr_cnt_any
    |=> {q.cnt_hi, q.cnt_lo} == $past({q.rl_hi, q.rl_lo}) && q.ctrl[CTRL_HFLAG])
    else $error("16-bit wrap did not reload or flag");

  chk_hold_stopped: assert property (
    !split && !run && !wr_cnt_any |=> $stable(cnt16))
    else $error("16-bit count moved while stopped");

  chk_low_free: assert property (
    split && !run && tick_lo && q.cnt_lo != BYTE_MAX && !wr_cnt_any
    |=> q.cnt_lo == $past(q.cnt_lo) + 8'h01 && $stable(q.cnt_hi))
    else $error("split low byte not free running");

  chk_low_wrap: assert property (
    split && tick_lo && q.cnt_lo == BYTE_MAX && !wr_cnt_any
    |=> q.cnt_lo == $past(q.rl_lo) && q.ctrl[CTRL_LFLAG])
    else $error("split low byte wrap wrong");

  chk_flag_sticky: assert property (
    q.ctrl[CTRL_HFLAG] && !wr_ctrl |=> q.ctrl[CTRL_HFLAG])
    else $error("high flag cleared by hardware");

  chk_capture_copy: assert property (
    q.ctrl[CTRL_CEN] && lfo_fall
    |=> {q.rl_hi, q.rl_lo} == $past(cnt16) && q.ctrl[CTRL_HFLAG])
    else $error("capture did not copy count");

  chk_irq_source: assert property (
    irq_o == (q.t_ie && (q.ctrl[CTRL_HFLAG] || (q.ctrl[CTRL_LIEN] && q.ctrl[CTRL_LFLAG]))))
    else $error("interrupt request does not match flags");

  chk_unused_zero: assert property (
    q.ctrl[CTRL_UNUSED] == 1'b0)
    else $error("unused control bit set");

  chk_div12_period: assert property (
    div12_tick |-> ##12 div12_tick)
    else $error("divide by twelve period wrong");

  chk_high_wrap: assert property (
    split && run && tick_hi && q.cnt_hi == BYTE_MAX && !wr_cnt_any
    |=> q.cnt_hi == $past(q.rl_hi) && q.ctrl[CTRL_HFLAG])
    else $error("split high byte wrap wrong");

  chk_run_count: assert property (
    !split && run && tick_lo && cnt16 != WORD_MAX && !wr_cnt_any
    |=> cnt16 == $past(cnt16) + 16'h0001)
    else $error("16-bit count did not advance");

  chk_low_flag16: assert property (
    !split && run && tick_lo && q.cnt_lo == BYTE_MAX
    |=> q.ctrl[CTRL_LFLAG])
    else $error("low flag not set in 16-bit mode");

  chk_low_sticky: assert property (
    q.ctrl[CTRL_LFLAG] && !wr_ctrl |=> q.ctrl[CTRL_LFLAG])
    else $error("low flag cleared by hardware");

  chk_read_upper: assert property (
    !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h000000)
    else $error("read data upper lanes not zero");

endmodule

// ### verif/artc_timer_tb_top.sv
module artc_timer_tb_top
  import artc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk;
  logic        rst_n;
  logic [7:0]  adr;
  logic        rd;
  logic        wr;
  logic [31:0] wdata;
  logic [3:0]  be;
  logic [31:0] rdata;
  logic        wait_req;
  logic        ext_osc;
  logic        low_frequency_oscillator;
  logic        irq;
  int          errors;
  int          checks;
  int          cycles;
  logic [7:0]  v;
  logic [7:0]  w;

  artc_timer u_artc_timer (
    .ref_clk_i         (clk),
    .rst_n_i           (rst_n),
    .avs_address_i     (adr),
    .avs_read_i        (rd),
    .avs_write_i       (wr),
    .avs_writedata_i   (wdata),
    .avs_byteenable_i  (be),
    .avs_readdata_o    (rdata),
    .avs_waitrequest_o (wait_req),
    .ext_osc_i         (ext_osc),
    .lfo_i             (low_frequency_oscillator),
    .irq_o             (irq)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // A hung handshake is cut short here.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      errors++;
      end_sim();
    end
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  // The request is held until the edge that samples waitrequest low.
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] b,
                     output logic [7:0] q);
    @(posedge clk);
    adr   <= a;
    wr    <= w;
    rd    <= ~w;
    wdata <= {PAD_ZERO, d};
    be    <= b;
    do @(posedge clk); while (wait_req !== 1'b0);
    q = rdata[7:0];
    if (!w) begin
      check("readdata upper", {7'h00, |rdata[31:8]}, 8'h00);
    end
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, 4'h1, q);
  endtask

  task automatic rreg(input logic [7:0] a, output logic [7:0] q);
    bus(1'b0, a, 8'h00, 4'h1, q);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [7:0] a [7] = '{ADDR_CTRL, ADDR_CNT_LO, ADDR_CNT_HI, ADDR_RL_LO, ADDR_RL_HI, ADDR_CKSEL, ADDR_IRQEN};
    foreach (a[i]) begin
      rreg(a[i], v);
      check("reset value", v, CTRL_RESET);
    end
    wreg(ADDR_RL_LO, 8'hA5);
    bus(1'b1, ADDR_RL_LO, 8'h5A, 4'h0, v);
    rreg(ADDR_RL_LO, v);
    check("reload low", v, 8'hA5);
    wreg(8'hF0, 8'h77);
    rreg(8'hF0, v);
    check("unmapped", v, 8'h00);
    wreg(ADDR_CTRL, 8'hFF);
    rreg(ADDR_CTRL, v);
    check("control unused bit", v, 8'hFD);
    wreg(ADDR_CTRL, 8'h00);
    rreg(ADDR_CTRL, v);
    check("control cleared", v, 8'h00);
  endtask

  task automatic t_wide();
    wreg(ADDR_CKSEL, 8'h30);
    wreg(ADDR_IRQEN, 8'h20);
    wreg(ADDR_RL_LO, 8'h34);
    wreg(ADDR_RL_HI, 8'h12);
    wreg(ADDR_CNT_LO, 8'hFA);
    wreg(ADDR_CNT_HI, 8'hFF);
    wreg(ADDR_CTRL, 8'h04);
    idle(10);
    check("irq on wrap", irq, 1'b1);
    rreg(ADDR_CTRL, v);
    check("flags on wrap", v, 8'hC4);
    wreg(ADDR_CTRL, 8'hC0);
    rreg(ADDR_CNT_HI, v);
    check("reloaded high", v, 8'h12);
    rreg(ADDR_CNT_LO, v);
    idle(20);
    rreg(ADDR_CNT_LO, w);
    check("held count", w, v);
    wreg(ADDR_CTRL, 8'h00);
    idle(1);
    check("irq after clear", irq, 1'b0);
    wreg(ADDR_CNT_HI, 8'h00);
    wreg(ADDR_CNT_LO, 8'hFE);
    wreg(ADDR_CTRL, 8'h04);
    idle(10);
    rreg(ADDR_CTRL, v);
    check("low flag 16-bit", v, 8'h44);
    wreg(ADDR_CTRL, 8'h40);
    idle(1);
    check("no low irq", irq, 1'b0);
    rreg(ADDR_CNT_HI, v);
    check("carry to high", v, 8'h01);
    wreg(ADDR_CTRL, 8'h60);
    idle(1);
    check("low irq", irq, 1'b1);
    wreg(ADDR_CTRL, 8'h20);
    idle(1);
    check("low irq cleared", irq, 1'b0);
  endtask

  task automatic t_split();
    wreg(ADDR_CTRL, 8'h00);
    wreg(ADDR_RL_LO, 8'hF0);
    wreg(ADDR_RL_HI, 8'hA0);
    wreg(ADDR_CNT_LO, 8'hFC);
    wreg(ADDR_CNT_HI, 8'hFE);
    wreg(ADDR_CTRL, 8'h08);
    idle(30);
    rreg(ADDR_CNT_HI, v);
    check("high gated", v, 8'hFE);
    rreg(ADDR_CTRL, v);
    check("low flag only", v, 8'h48);
    check("no irq", irq, 1'b0);
    rreg(ADDR_CNT_LO, v);
    check("low reload range", v >= 8'hF0, 1'b1);
    wreg(ADDR_CTRL, 8'h0C);
    idle(20);
    rreg(ADDR_CTRL, v);
    check("high flag", v[7], 1'b1);
    check("high irq", irq, 1'b1);
    rreg(ADDR_CNT_HI, v);
    check("high reload range", v >= 8'hA0 && v < 8'hD0, 1'b1);
    wreg(ADDR_CTRL, 8'h28);
    idle(20);
    check("low irq split", irq, 1'b1);
  endtask

  task automatic t_clocks();
    wreg(ADDR_CTRL, 8'h00);
    wreg(ADDR_CKSEL, 8'h00);
    wreg(ADDR_CNT_LO, 8'h00);
    wreg(ADDR_CNT_HI, 8'h00);
    wreg(ADDR_CTRL, 8'h04);
    idle(120);
    wreg(ADDR_CTRL, 8'h00);
    rreg(ADDR_CNT_LO, v);
    check("div12 count", v >= 8'h09 && v <= 8'h0B, 1'b1);
    wreg(ADDR_CNT_LO, 8'h00);
    wreg(ADDR_CTRL, 8'h05);
    repeat (32) begin
      ext_osc <= 1'b1;
      idle(2);
      ext_osc <= 1'b0;
      idle(2);
    end
    idle(10);
    wreg(ADDR_CTRL, 8'h00);
    rreg(ADDR_CNT_LO, v);
    check("ext div8 count", v, 8'h04);
  endtask

  task automatic t_capture();
    wreg(ADDR_IRQEN, 8'h00);
    wreg(ADDR_CKSEL, 8'h10);
    wreg(ADDR_CNT_LO, 8'h00);
    wreg(ADDR_RL_LO, 8'h00);
    wreg(ADDR_RL_HI, 8'h00);
    wreg(ADDR_CTRL, 8'h14);
    idle(50);
    low_frequency_oscillator <= 1'b0;
    idle(10);
    rreg(ADDR_CTRL, v);
    check("capture flag", v[7], 1'b1);
    rreg(ADDR_RL_HI, v);
    check("capture high", v, 8'h00);
    rreg(ADDR_RL_LO, v);
    check("capture low", v >= 8'h28 && v <= 8'h50, 1'b1);
  endtask

  initial begin
    rst_n   = 1'b0;
    adr     = 8'h00;
    rd      = 1'b0;
    wr      = 1'b0;
    wdata   = 32'h0000_0000;
    be      = 4'h0;
    ext_osc = 1'b0;
    low_frequency_oscillator     = 1'b1;
    errors  = 0;
    checks  = 0;
    cycles  = 0;
    idle(5);
    rst_n <= 1'b1;
    idle(1);
    t_regs();
    t_wide();
    t_split();
    t_clocks();
    t_capture();
    end_sim();
  end

endmodule
